// ---- see_pkg.sv ----
// Constants for the serial EEPROM pin-level slave.
// Assumes a 100 MHz system clock sampling every pin through synchronisers.
package see_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELECT_LOW_MIN_TIME_NS = 250;
  // Least time, so round up
  localparam int SELECT_LOW_MIN_CYC =
    (SELECT_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOWCNT_W = 6;

  // ----------------------------------------------------------------------
  // Instruction framing
  // ----------------------------------------------------------------------
  localparam int OPC_W  = 2;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int CNT_W  = 5;

  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;

  // Sub-codes in the top two address bits of the extended opcode
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PG_NONE,
    PG_WRITE,
    PG_ERASE,
    PG_ERASE_ALL,
    PG_WRITE_ALL
  } see_prog_type;

  typedef enum logic [2:0] {
    ST_WAIT_START,
    ST_SHIFT_CMD,
    ST_SHIFT_DATA,
    ST_READ_OUT,
    ST_DONE
  } see_state_type;

endpackage : see_pkg

// ---- see_pin_slave.sv ----
// Pin-level three-wire serial EEPROM slave with flip-flop storage.
// Assumes all pins are asynchronous to clk_sys and much slower than it.
// Functional notes
// - Select high selects the device; select low puts it in standby.
// - A started programming cycle always runs to its end.
// - Select low during programming gives standby after the cycle ends.
// - Select low holds the instruction decoder in reset.
// - Opcode, address and data bits are sampled on serial clock rises.
// - Read data on the serial output changes after each rising clock edge.
// - The serial clock may pause at any level without losing state.
// - Serial clock activity is ignored while select is low.
// - Without a start bit, clock edges change nothing; it keeps waiting.
// - Self-timed programming needs no serial clock edges.
// - After a full non-read instruction, clock and input are ignored until select goes low; a read keeps shifting out data.
// - Input carries start bit, opcode, address, data, clocked serially.
// - Select raised after its low time during programming shows status.
// - Select low for the whole cycle shows no status; output stays off.
// - Status checked after the cycle ended drives the output high.
// - Word width select high gives 16-bit words, low gives 8-bit words.
// - Start is the first clock rise with select and input both high while no programming cycle runs.
// - During status, output low means busy and high means ready.
// - Serial output goes off on every falling edge of select.
`timescale 1ns/1ns

module see_pin_slave #(
  parameter int ADDR_W      = 7,
  parameter int PROG_CYCLES = 500000
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  input  wire logic word_width_select,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  output logic      standby,
  output logic      busy
);

  localparam int NBYTES = 2 ** (ADDR_W + 1);
  localparam int CMD_W  = see_pkg::OPC_W + ADDR_W + 1;
  localparam int PCNT_W = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  logic di_s1_q, di_s2_q;
  logic org_s1_q, org_s2_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s1_q  <= 1'b0;
      cs_s2_q  <= 1'b0;
      cs_s3_q  <= 1'b0;
      ck_s1_q  <= 1'b0;
      ck_s2_q  <= 1'b0;
      ck_s3_q  <= 1'b0;
      di_s1_q  <= 1'b0;
      di_s2_q  <= 1'b0;
      org_s1_q <= 1'b0;
      org_s2_q <= 1'b0;
    end
    else
    begin
      cs_s1_q  <= chip_select;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      ck_s1_q  <= serial_clock;
      ck_s2_q  <= ck_s1_q;
      ck_s3_q  <= ck_s2_q;
      di_s1_q  <= serial_in;
      di_s2_q  <= di_s1_q;
      org_s1_q <= word_width_select;
      org_s2_q <= org_s1_q;
    end
  end

  logic cs_fall, cs_rise, ck_rise;
  assign cs_fall = cs_s3_q & ~cs_s2_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  // Only edges count, so a paused clock simply produces no work
  assign ck_rise = cs_s2_q & ck_s2_q & ~ck_s3_q;

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  see_pkg::see_state_type state_q;
  see_pkg::see_prog_type  pend_q;
  logic [CMD_W-1:0]              cmd_q;
  logic [see_pkg::WORD_W-1:0]    wdat_q;
  logic [see_pkg::WORD_W-1:0]    rd_q;
  logic [see_pkg::CNT_W-1:0]     cnt_q;
  logic [ADDR_W:0]               ptr_q;
  logic                          x16_q;
  logic                          en_q;
  logic                          do_q;
  logic                          rd_drv_q;
  logic [PCNT_W-1:0]             pcnt_q;
  logic [see_pkg::BYTE_W-1:0]    mem_q [NBYTES];

  logic                 start_det;
  logic [CMD_W-1:0]     cmd_new;
  logic [see_pkg::CNT_W-1:0] cmd_len;
  logic [see_pkg::CNT_W-1:0] wlen;
  logic [1:0]           opc;
  logic [1:0]           ext;
  logic [ADDR_W:0]      addr;
  logic [ADDR_W:0]      step;

  assign start_det = ck_rise & di_s2_q & (state_q == see_pkg::ST_WAIT_START)
                     & ~busy;
  assign cmd_new   = {cmd_q[CMD_W-2:0], di_s2_q};
  assign cmd_len   = x16_q ? see_pkg::CNT_W'(see_pkg::OPC_W + ADDR_W)
                           : see_pkg::CNT_W'(see_pkg::OPC_W + ADDR_W + 1);
  assign wlen      = x16_q ? see_pkg::CNT_W'(see_pkg::WORD_W)
                           : see_pkg::CNT_W'(see_pkg::BYTE_W);
  assign step      = x16_q ? (ADDR_W+1)'(2) : (ADDR_W+1)'(1);

  // Opcode as latched; cmd_new is shifted again once data bits arrive
  logic [1:0]           opc_held;
  assign opc_held  = x16_q ? cmd_q[ADDR_W+1:ADDR_W]
                           : cmd_q[ADDR_W+2:ADDR_W+1];

  always_comb
  begin
    if (x16_q)
    begin
      opc  = cmd_new[ADDR_W+1:ADDR_W];
      ext  = cmd_new[ADDR_W-1:ADDR_W-2];
      addr = {cmd_new[ADDR_W-1:0], 1'b0};
    end
    else
    begin
      opc  = cmd_new[ADDR_W+2:ADDR_W+1];
      ext  = cmd_new[ADDR_W:ADDR_W-1];
      addr = cmd_new[ADDR_W:0];
    end
  end

  function automatic logic [see_pkg::WORD_W-1:0] fetch(
    input logic [ADDR_W:0] a,
    input logic            wide
  );
    logic [ADDR_W:0] b;
    b = a | (ADDR_W+1)'(1);
    if (wide)
      fetch = {mem_q[a], mem_q[b]};
    else
      fetch = {mem_q[a], see_pkg::BYTE_W'(0)};
  endfunction : fetch

  // ----------------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= see_pkg::ST_WAIT_START;
      pend_q   <= see_pkg::PG_NONE;
      cmd_q    <= '0;
      wdat_q   <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      ptr_q    <= '0;
      x16_q    <= 1'b0;
      en_q     <= 1'b0;
      do_q     <= 1'b0;
      rd_drv_q <= 1'b0;
    end
    else if (!cs_s2_q)
    begin
      // Deselect resets decode; a pending program is kept for the launch
      state_q  <= see_pkg::ST_WAIT_START;
      cmd_q    <= '0;
      cnt_q    <= '0;
      rd_drv_q <= 1'b0;
      if (!cs_fall)
        pend_q <= see_pkg::PG_NONE;
    end
    else if (ck_rise)
    begin
      case (state_q)
        see_pkg::ST_WAIT_START:
        begin
          if (start_det)
          begin
            state_q <= see_pkg::ST_SHIFT_CMD;
            x16_q   <= org_s2_q;
            cmd_q   <= '0;
            cnt_q   <= '0;
          end
        end
        see_pkg::ST_SHIFT_CMD:
        begin
          cmd_q <= cmd_new;
          cnt_q <= cnt_q + see_pkg::CNT_W'(1);
          if (cnt_q == cmd_len - see_pkg::CNT_W'(1))
          begin
            cnt_q <= '0;
            ptr_q <= addr;
            case (opc)
              see_pkg::OPC_READ:
              begin
                // Dummy zero leads the data
                state_q  <= see_pkg::ST_READ_OUT;
                rd_q     <= fetch(addr, x16_q);
                do_q     <= 1'b0;
                rd_drv_q <= 1'b1;
              end
              see_pkg::OPC_WRITE:
                state_q <= see_pkg::ST_SHIFT_DATA;
              see_pkg::OPC_ERASE:
              begin
                state_q <= see_pkg::ST_DONE;
                pend_q  <= see_pkg::PG_ERASE;
              end
              default:
              begin
                case (ext)
                  see_pkg::EXT_WRITE_ALL:
                    state_q <= see_pkg::ST_SHIFT_DATA;
                  see_pkg::EXT_ERASE_ALL:
                  begin
                    state_q <= see_pkg::ST_DONE;
                    pend_q  <= see_pkg::PG_ERASE_ALL;
                  end
                  see_pkg::EXT_ENABLE:
                  begin
                    state_q <= see_pkg::ST_DONE;
                    en_q    <= 1'b1;
                  end
                  default:
                  begin
                    state_q <= see_pkg::ST_DONE;
                    en_q    <= 1'b0;
                  end
                endcase
              end
            endcase
          end
        end
        see_pkg::ST_SHIFT_DATA:
        begin
          wdat_q <= {wdat_q[see_pkg::WORD_W-2:0], di_s2_q};
          cnt_q  <= cnt_q + see_pkg::CNT_W'(1);
          if (cnt_q == wlen - see_pkg::CNT_W'(1))
          begin
            state_q <= see_pkg::ST_DONE;
            pend_q  <= (opc_held == see_pkg::OPC_EXT) ? see_pkg::PG_WRITE_ALL
                                                      : see_pkg::PG_WRITE;
          end
        end
        see_pkg::ST_READ_OUT:
        begin
          do_q  <= rd_q[see_pkg::WORD_W-1];
          rd_q  <= {rd_q[see_pkg::WORD_W-2:0], 1'b0};
          cnt_q <= cnt_q + see_pkg::CNT_W'(1);
          if (cnt_q == wlen - see_pkg::CNT_W'(1))
          begin
            // Sequential read rolls on to the next word
            cnt_q <= '0;
            ptr_q <= ptr_q + step;
            rd_q  <= fetch(ptr_q + step, x16_q);
          end
        end
        see_pkg::ST_DONE:
          state_q <= see_pkg::ST_DONE;
        default:
          state_q <= see_pkg::ST_WAIT_START;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Self-timed programming
  // ----------------------------------------------------------------------
  logic prog_go;
  assign prog_go = cs_fall & (state_q == see_pkg::ST_DONE)
                   & (pend_q != see_pkg::PG_NONE) & en_q & ~busy;

  // Runs from clk_sys alone, so no serial clock is needed to finish
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcnt_q <= '0;
      busy   <= 1'b0;
    end
    else if (prog_go)
    begin
      pcnt_q <= PCNT_W'(PROG_CYCLES);
      busy   <= 1'b1;
    end
    else if (busy)
    begin
      pcnt_q <= pcnt_q - PCNT_W'(1);
      if (pcnt_q == PCNT_W'(1))
        busy <= 1'b0;
    end
  end

  // Array is updated at launch; the counter only models the wait
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NBYTES; i++)
        mem_q[i] <= see_pkg::ERASED_BYTE;
    end
    else if (prog_go)
    begin
      case (pend_q)
        see_pkg::PG_WRITE:
        begin
          if (x16_q)
          begin
            mem_q[ptr_q] <= wdat_q[see_pkg::WORD_W-1:see_pkg::BYTE_W];
            mem_q[ptr_q | (ADDR_W+1)'(1)] <= wdat_q[see_pkg::BYTE_W-1:0];
          end
          else
            mem_q[ptr_q] <= wdat_q[see_pkg::BYTE_W-1:0];
        end
        see_pkg::PG_ERASE:
        begin
          mem_q[ptr_q] <= see_pkg::ERASED_BYTE;
          if (x16_q)
            mem_q[ptr_q | (ADDR_W+1)'(1)] <= see_pkg::ERASED_BYTE;
        end
        see_pkg::PG_ERASE_ALL:
        begin
          for (int i = 0; i < NBYTES; i++)
            mem_q[i] <= see_pkg::ERASED_BYTE;
        end
        see_pkg::PG_WRITE_ALL:
        begin
          for (int i = 0; i < NBYTES; i++)
            if (x16_q && (i % 2 == 0))
              mem_q[i] <= wdat_q[see_pkg::WORD_W-1:see_pkg::BYTE_W];
            else
              mem_q[i] <= wdat_q[see_pkg::BYTE_W-1:0];
        end
        default:
          mem_q[0] <= mem_q[0];
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Ready/busy status and output pin
  // ----------------------------------------------------------------------
  localparam int LOWCNT_W_L = see_pkg::LOWCNT_W;
  logic [LOWCNT_W_L-1:0] low_cnt_q;
  logic armed_q;
  logic status_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt_q <= '0;
    else if (cs_s2_q)
      low_cnt_q <= '0;
    else if (low_cnt_q < LOWCNT_W_L'(see_pkg::SELECT_LOW_MIN_CYC))
      low_cnt_q <= low_cnt_q + LOWCNT_W_L'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q  <= 1'b0;
      status_q <= 1'b0;
    end
    else
    begin
      // Launch wins over a start bit in the same cycle
      if (prog_go)
        armed_q <= 1'b1;
      else if (start_det)
        armed_q <= 1'b0;
      if (cs_fall || start_det)
        status_q <= 1'b0;
      else if (cs_rise && armed_q &&
               low_cnt_q >= LOWCNT_W_L'(see_pkg::SELECT_LOW_MIN_CYC))
        status_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
      standby         <= 1'b1;
    end
    else
    begin
      serial_out      <= status_q ? ~busy : do_q;
      serial_out_oe_n <= ~((status_q | rd_drv_q) & cs_s2_q);
      standby         <= ~cs_s2_q & ~busy & ~prog_go;
    end
  end

endmodule : see_pin_slave

// ---- see_pin_slave_props.sv ----
// Pin-level assertions for the serial EEPROM slave.
// Assumes it is bound to see_pin_slave and sees only its ports.
`timescale 1ns/1ns
module see_pin_slave_props #(
  parameter int ADDR_W      = 7,
  parameter int PROG_CYCLES = 500000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic word_width_select,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic standby,
  input wire logic busy
);
  // ------
  // Programming length, standby and status output
  // ------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic [31:0] busy_cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      busy_cnt_q <= '0;
    else if (busy)
      busy_cnt_q <= busy_cnt_q + 32'h1;
    else
      busy_cnt_q <= '0;

  // Sync latency makes one cycle of slack unavoidable
  sequence desel_idle_s;
    (!chip_select && !busy)[*8];
  endsequence
  sequence status_busy_s;
    !serial_out_oe_n && busy;
  endsequence

  standby_idle_a: assert property (desel_idle_s |-> standby)
    else $error("standby missing while deselected");
  select_wake_a: assert property ($rose(chip_select) |-> ##[1:5] !standby)
    else $error("standby kept after select");
  prog_length_a: assert property ($fell(busy) |->
    busy_cnt_q >= PROG_CYCLES - 1 && busy_cnt_q <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  prog_bound_a: assert property (busy_cnt_q <= PROG_CYCLES + 1)
    else $error("programming never ends");
  busy_awake_a: assert property (busy |-> !standby)
    else $error("standby during programming");
  status_low_a: assert property (status_busy_s |-> !serial_out)
    else $error("busy status not low");
  ready_high_a: assert property ($fell(busy) && !serial_out_oe_n |->
    ##[0:2] (serial_out || serial_out_oe_n))
    else $error("ready status not high");
  out_release_a: assert property ($fell(chip_select) |->
    ##[1:4] serial_out_oe_n)
    else $error("output kept after select fall");
  desel_quiet_a: assert property ((!chip_select)[*6] |->
    serial_out_oe_n)
    else $error("output driven while deselected");
endmodule : see_pin_slave_props

bind see_pin_slave see_pin_slave_props #(
  .ADDR_W      (ADDR_W),
  .PROG_CYCLES (PROG_CYCLES)
) u_props (
  .clk_sys           (clk_sys),
  .rst_n             (rst_n),
  .chip_select       (chip_select),
  .serial_clock      (serial_clock),
  .serial_in         (serial_in),
  .word_width_select (word_width_select),
  .serial_out        (serial_out),
  .serial_out_oe_n   (serial_out_oe_n),
  .standby           (standby),
  .busy              (busy)
);

// ---- see_master_model.sv ----
// Behavioural master driving select, serial clock and data.
// Assumes the bench calls its tasks; serial clock period is 80 ns.
`timescale 1ns/1ns
module see_master_model (
  input  wire logic clk_sys,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in,
  output logic      word_width_select
);
  // ------
  // Pin drivers
  // ------
  // A released line shows the inverse, so a sample taken undriven fails
  logic do_line;
  assign do_line = serial_out_oe_n ? ~serial_out : serial_out;

  initial
  begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    word_width_select = 1'b1;
  end

  task automatic width(input logic w);
    @(posedge clk_sys);
    #1 word_width_select = w;
  endtask : width

  task automatic select();
    @(posedge clk_sys);
    #1 chip_select = 1'b1;
  endtask : select

  // Longer than the minimum low time so status is armed
  task automatic deselect();
    @(posedge clk_sys);
    #1 chip_select = 1'b0;
    #300;
  endtask : deselect

  // Serial clock stands low between calls
  task automatic frame(input logic [31:0] bits, input int n,
                       output logic [31:0] cap);
    cap = '0;
    @(posedge clk_sys);
    #1 chip_select = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = bits[i];
      #40 cap = {cap[30:0], do_line};
      serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
    end
    serial_in = 1'b0;
  endtask : frame

  task automatic pulses(input int n, input logic din);
    @(posedge clk_sys);
    #1 serial_in = din;
    repeat (n)
    begin
      #40 serial_clock = 1'b1;
      #40 serial_clock = 1'b0;
    end
    serial_in = 1'b0;
  endtask : pulses
endmodule : see_master_model

// ---- see_pin_slave_bench.sv ----
// Self-checking bench for the serial EEPROM slave.
// Assumes see_master_model drives the pins; short programming time.
`timescale 1ns/1ns
module see_pin_slave_bench;
  // ------
  // Harness
  // ------
  localparam int PROG = 100;
  logic clk_sys;
  logic rst_n;
  wire  chip_select;
  wire  serial_clock;
  wire  serial_in;
  wire  word_width_select;
  wire  serial_out;
  wire  serial_out_oe_n;
  wire  standby;
  wire  busy;
  int   n_mismatch;
  int   total_checks;

  see_pin_slave #(.ADDR_W(7), .PROG_CYCLES(PROG)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .word_width_select(word_width_select), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .standby(standby), .busy(busy));

  see_master_model m (
    .clk_sys(clk_sys), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .word_width_select(word_width_select));

  always #5 clk_sys = ~clk_sys;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 2000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (busy !== v)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_busy

  // ------
  // Scenarios
  // ------
  task automatic sc_reset_state();
    check(32'({standby, busy, serial_out_oe_n}), 32'h5);
    m.select();
    repeat (8) @(posedge clk_sys);
    #1;
    check(32'(standby), 32'h0);
    m.deselect();
    check(32'(standby), 32'h1);
  endtask : sc_reset_state

  // Extra edges after the frame must not disturb the write
  task automatic prog(input logic [31:0] cmd, input int n, input bit hold);
    logic [31:0] cap;
    m.frame(cmd, n, cap);
    m.pulses(3, 1'b1);
    m.deselect();
    check(32'(busy), 32'h1);
    if (hold)
    begin
      m.pulses(4, 1'b1);
      check(32'({busy, standby}), 32'h2);
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      check(32'({standby, serial_out_oe_n}), 32'h3);
    end
    else
    begin
      m.select();
      repeat (6) @(posedge clk_sys);
      #1;
      check(32'({serial_out_oe_n, serial_out}), 32'h0);
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      check(32'({serial_out_oe_n, serial_out}), 32'h1);
      m.deselect();
    end
  endtask : prog

  // Idle edges with data low come first and must be ignored
  task automatic read_chk(input logic [31:0] cmd, input int n,
                          input logic [16:0] exp, input logic [16:0] msk);
    logic [31:0] cap;
    m.select();
    m.pulses(20, 1'b0);
    m.frame(cmd, n, cap);
    m.deselect();
    check(32'(cap[16:0] & msk), 32'(exp));
  endtask : read_chk

  task automatic sc_word_write();
    logic [31:0] cap;
    m.frame({22'h0, 10'b1001100000}, 10, cap);
    m.deselect();
    prog({3'b101, 7'h05, 16'ha5c3}, 26, 1'b0);
    read_chk({3'b110, 7'h05, 17'h0}, 27, {1'b0, 16'ha5c3}, 17'h1ffff);
  endtask : sc_word_write

  task automatic sc_write_held_low();
    prog({3'b101, 7'h7f, 16'h0f1e}, 26, 1'b1);
    read_chk({3'b110, 7'h7f, 17'h0}, 27, {1'b0, 16'h0f1e}, 17'h1ffff);
  endtask : sc_write_held_low

  task automatic sc_byte_mode();
    m.width(1'b0);
    prog({3'b101, 8'h23, 8'h96}, 19, 1'b0);
    read_chk({3'b110, 8'h23, 9'h0}, 20, 17'h00096, 17'h001ff);
    m.width(1'b1);
  endtask : sc_byte_mode

  // Erase, write-all, erase-all, then a write refused after disable
  task automatic sc_other_cmds();
    logic [31:0] cap;
    prog({22'h0, 3'b111, 7'h05}, 10, 1'b0);
    read_chk({3'b110, 7'h05, 17'h0}, 27, {1'b0, 16'hffff}, 17'h1ffff);
    prog({3'b100, 7'h20, 16'h1234}, 26, 1'b0);
    read_chk({3'b110, 7'h00, 17'h0}, 27, {1'b0, 16'h1234}, 17'h1ffff);
    read_chk({3'b110, 7'h7f, 17'h0}, 27, {1'b0, 16'h1234}, 17'h1ffff);
    prog({22'h0, 3'b100, 7'h40}, 10, 1'b1);
    read_chk({3'b110, 7'h33, 17'h0}, 27, {1'b0, 16'hffff}, 17'h1ffff);
    m.frame({22'h0, 3'b100, 7'h00}, 10, cap);
    m.deselect();
    m.frame({3'b101, 7'h33, 16'h0000}, 26, cap);
    m.deselect();
    check(32'(busy), 32'h0);
    read_chk({3'b110, 7'h33, 17'h0}, 27, {1'b0, 16'hffff}, 17'h1ffff);
  endtask : sc_other_cmds

  initial
  begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    sc_reset_state();
    sc_word_write();
    sc_write_held_low();
    sc_byte_mode();
    sc_other_cmds();
    complete_run();
  end
endmodule : see_pin_slave_bench
